// file: verilog/ioxp_pkg.sv
// Constants for the 16-bit I/O expander: slave address, register map,
// reset values, slot layout of the read/write bank and the serial states.
// Assumes every user writes ioxp_pkg::name; nothing is imported.
package ioxp_pkg;

  // Fixed upper six bits of the seven-bit slave address
  localparam logic [5:0] IOXP_ADDR_HI = 6'h10;

  // Register offsets (pointer values)
  localparam logic [7:0] IOXP_OFF_INPUT0 = 8'h00;
  localparam logic [7:0] IOXP_OFF_INPUT1 = 8'h01;
  localparam logic [7:0] IOXP_OFF_OUTPUT0 = 8'h02;
  localparam logic [7:0] IOXP_OFF_OUTPUT1 = 8'h03;
  localparam logic [7:0] IOXP_OFF_INVERT0 = 8'h04;
  localparam logic [7:0] IOXP_OFF_INVERT1 = 8'h05;
  localparam logic [7:0] IOXP_OFF_DIR0 = 8'h06;
  localparam logic [7:0] IOXP_OFF_DIR1 = 8'h07;
  localparam logic [7:0] IOXP_OFF_DRIVE0_LO = 8'h40;
  localparam logic [7:0] IOXP_OFF_DRIVE0_HI = 8'h41;
  localparam logic [7:0] IOXP_OFF_DRIVE1_LO = 8'h42;
  localparam logic [7:0] IOXP_OFF_DRIVE1_HI = 8'h43;
  localparam logic [7:0] IOXP_OFF_LATCH0 = 8'h44;
  localparam logic [7:0] IOXP_OFF_LATCH1 = 8'h45;
  localparam logic [7:0] IOXP_OFF_PULL_EN0 = 8'h46;
  localparam logic [7:0] IOXP_OFF_PULL_EN1 = 8'h47;
  localparam logic [7:0] IOXP_OFF_PULL_SEL0 = 8'h48;
  localparam logic [7:0] IOXP_OFF_PULL_SEL1 = 8'h49;
  localparam logic [7:0] IOXP_OFF_MASK0 = 8'h4A;
  localparam logic [7:0] IOXP_OFF_MASK1 = 8'h4B;
  localparam logic [7:0] IOXP_OFF_FLAGS0 = 8'h4C;
  localparam logic [7:0] IOXP_OFF_FLAGS1 = 8'h4D;
  localparam logic [7:0] IOXP_OFF_MODE = 8'h4F;

  // Pointer bit that selects the extended bank
  localparam int IOXP_PTR_EXT_BIT = 6;

  // Reset values
  localparam logic [7:0] IOXP_RST_OUTPUT = 8'hFF;
  localparam logic [7:0] IOXP_RST_INVERT = 8'h00;
  localparam logic [7:0] IOXP_RST_DIR = 8'hFF;
  localparam logic [7:0] IOXP_RST_DRIVE = 8'hFF;
  localparam logic [7:0] IOXP_RST_LATCH = 8'h00;
  localparam logic [7:0] IOXP_RST_PULL_EN = 8'h00;
  localparam logic [7:0] IOXP_RST_PULL_SEL = 8'hFF;
  localparam logic [7:0] IOXP_RST_MASK = 8'hFF;
  localparam logic [7:0] IOXP_RST_FLAGS = 8'h00;
  localparam logic [7:0] IOXP_RST_MODE = 8'h00;
  localparam logic [7:0] IOXP_RST_PTR = 8'h00;

  // Read/write bank: slot number of the first register of each group
  localparam int IOXP_NRW = 19;
  localparam logic [4:0] IOXP_SLOT_OUTPUT = 5'h00;
  localparam logic [4:0] IOXP_SLOT_INVERT = 5'h02;
  localparam logic [4:0] IOXP_SLOT_DIR = 5'h04;
  localparam logic [4:0] IOXP_SLOT_DRIVE = 5'h06;
  localparam logic [4:0] IOXP_SLOT_LATCH = 5'h0A;
  localparam logic [4:0] IOXP_SLOT_PULL_EN = 5'h0C;
  localparam logic [4:0] IOXP_SLOT_PULL_SEL = 5'h0E;
  localparam logic [4:0] IOXP_SLOT_MASK = 5'h10;
  localparam logic [4:0] IOXP_SLOT_MODE = 5'h12;
  localparam logic [4:0] IOXP_SLOT_NONE = 5'h1F;

  // Output mode bits: open-drain per port
  localparam int IOXP_MODE_OD0_BIT = 0;
  localparam int IOXP_MODE_OD1_BIT = 1;

  // Reset table of the bank, highest slot first
  localparam logic [IOXP_NRW-1:0][7:0] IOXP_RW_RST = {
    IOXP_RST_MODE,
    IOXP_RST_MASK, IOXP_RST_MASK,
    IOXP_RST_PULL_SEL, IOXP_RST_PULL_SEL,
    IOXP_RST_PULL_EN, IOXP_RST_PULL_EN,
    IOXP_RST_LATCH, IOXP_RST_LATCH,
    IOXP_RST_DRIVE, IOXP_RST_DRIVE, IOXP_RST_DRIVE, IOXP_RST_DRIVE,
    IOXP_RST_DIR, IOXP_RST_DIR,
    IOXP_RST_INVERT, IOXP_RST_INVERT,
    IOXP_RST_OUTPUT, IOXP_RST_OUTPUT};

  // Serial slave states
  typedef enum logic [2:0] {
    IOXP_S_IDLE = 3'h0,
    IOXP_S_RX = 3'h1,
    IOXP_S_RXEND = 3'h2,
    IOXP_S_ACK = 3'h3,
    IOXP_S_TX = 3'h4,
    IOXP_S_RACK = 3'h5,
    IOXP_S_RACKF = 3'h6
  } ioxp_state_t;

endpackage

// file: verilog/ioxp_i2c_slave.sv
// Byte engine of the two-wire slave: start/stop, address match, ack,
// receive and send of bytes. Assumes scl_i and sda_i are already
// synchronised to clk_i and that rd_data_i is valid in the cycle before rd_stb_o fires.
`timescale 1ns/1ps
module ioxp_i2c_slave (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic addr_sel_i,
  input wire logic [7:0] rd_data_i,
  output logic sda_oe_o,
  output logic wr_stb_o,
  output logic wr_cmd_o,
  output logic [7:0] wr_data_o,
  output logic rd_stb_o
);

  ioxp_pkg::ioxp_state_t state_r, state_nxt;
  logic scl_q_r, sda_q_r;
  logic [7:0] shift_r, shift_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic addr_ph_r, addr_ph_nxt;
  logic read_r, read_nxt;
  logic cmd_r, cmd_nxt;
  logic wr_stb_r, wr_stb_nxt;
  logic wr_cmd_r, wr_cmd_nxt;
  logic [7:0] wr_data_r, wr_data_nxt;
  logic rd_stb_r, rd_stb_nxt;

  // Bus events from the synchronised lines
  wire scl_rise = scl_i & ~scl_q_r;
  wire scl_fall = ~scl_i & scl_q_r;
  wire start_det = scl_i & scl_q_r & sda_q_r & ~sda_i;
  wire stop_det = scl_i & scl_q_r & ~sda_q_r & sda_i;
  wire addr_hit = (shift_r[7:1] == {ioxp_pkg::IOXP_ADDR_HI, addr_sel_i});

  // Next-state logic; start and stop win over any bit in flight
  always_comb
  begin
    state_nxt = state_r;
    shift_nxt = shift_r;
    cnt_nxt = cnt_r;
    addr_ph_nxt = addr_ph_r;
    read_nxt = read_r;
    cmd_nxt = cmd_r;
    wr_stb_nxt = 1'b0;
    wr_cmd_nxt = wr_cmd_r;
    wr_data_nxt = wr_data_r;
    rd_stb_nxt = 1'b0;
    if (start_det)
    begin
      state_nxt = ioxp_pkg::IOXP_S_RX;
      cnt_nxt = 3'h0;
      addr_ph_nxt = 1'b1;
    end
    else if (stop_det)
      state_nxt = ioxp_pkg::IOXP_S_IDLE;
    else
      unique case (state_r)
        ioxp_pkg::IOXP_S_IDLE: ;
        ioxp_pkg::IOXP_S_RX:
          if (scl_rise)
          begin
            shift_nxt = {shift_r[6:0], sda_i};
            cnt_nxt = cnt_r + 3'h1;
            if (cnt_r == 3'h7)
              state_nxt = ioxp_pkg::IOXP_S_RXEND;
          end
        ioxp_pkg::IOXP_S_RXEND:
          if (scl_fall)
          begin
            if (addr_ph_r)
            begin
              // Foreign address: stay off the bus until the next start
              state_nxt = addr_hit ? ioxp_pkg::IOXP_S_ACK : ioxp_pkg::IOXP_S_IDLE;
              read_nxt = shift_r[0];
              cmd_nxt = ~shift_r[0];
            end
            else
            begin
              state_nxt = ioxp_pkg::IOXP_S_ACK;
              wr_stb_nxt = 1'b1;
              wr_cmd_nxt = cmd_r;
              wr_data_nxt = shift_r;
              cmd_nxt = 1'b0;
            end
          end
        ioxp_pkg::IOXP_S_ACK:
          if (scl_fall)
          begin
            cnt_nxt = 3'h0;
            addr_ph_nxt = 1'b0;
            if (addr_ph_r && read_r)
            begin
              state_nxt = ioxp_pkg::IOXP_S_TX;
              shift_nxt = rd_data_i;
              rd_stb_nxt = 1'b1;
            end
            else
              state_nxt = ioxp_pkg::IOXP_S_RX;
          end
        ioxp_pkg::IOXP_S_TX:
          if (scl_fall)
          begin
            shift_nxt = {shift_r[6:0], 1'b1};
            cnt_nxt = cnt_r + 3'h1;
            if (cnt_r == 3'h7)
              state_nxt = ioxp_pkg::IOXP_S_RACK;
          end
        ioxp_pkg::IOXP_S_RACK:
          if (scl_rise)
            state_nxt = sda_i ? ioxp_pkg::IOXP_S_IDLE : ioxp_pkg::IOXP_S_RACKF;
        ioxp_pkg::IOXP_S_RACKF:
          if (scl_fall)
          begin
            state_nxt = ioxp_pkg::IOXP_S_TX;
            shift_nxt = rd_data_i;
            rd_stb_nxt = 1'b1;
          end
        default:
          state_nxt = ioxp_pkg::IOXP_S_IDLE;
      endcase
  end

  // State and strobe registers
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_r <= ioxp_pkg::IOXP_S_IDLE;
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
      shift_r <= 8'h00;
      cnt_r <= 3'h0;
      addr_ph_r <= 1'b0;
      read_r <= 1'b0;
      cmd_r <= 1'b0;
      wr_stb_r <= 1'b0;
      wr_cmd_r <= 1'b0;
      wr_data_r <= 8'h00;
      rd_stb_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      scl_q_r <= scl_i;
      sda_q_r <= sda_i;
      shift_r <= shift_nxt;
      cnt_r <= cnt_nxt;
      addr_ph_r <= addr_ph_nxt;
      read_r <= read_nxt;
      cmd_r <= cmd_nxt;
      wr_stb_r <= wr_stb_nxt;
      wr_cmd_r <= wr_cmd_nxt;
      wr_data_r <= wr_data_nxt;
      rd_stb_r <= rd_stb_nxt;
    end
  end

  // Pull SDA low for ack and for zero data bits; only the state and shift flops feed it
  assign sda_oe_o = (state_r == ioxp_pkg::IOXP_S_ACK) |
                    ((state_r == ioxp_pkg::IOXP_S_TX) & ~shift_r[7]);
  assign wr_stb_o = wr_stb_r;
  assign wr_cmd_o = wr_cmd_r;
  assign wr_data_o = wr_data_r;
  assign rd_stb_o = rd_stb_r;

endmodule // ioxp_i2c_slave

// file: verilog/ioxp_expander.sv
// Top of the 16-bit I/O expander: reset release, pin synchronisers,
// pointer register, register banks, input capture and change flags.
// Assumes SCL/SDA/ADDR/port levels arrive asynchronously on pins and that
// the pad ring resolves the open-drain SDA line from sda_oe_o.
`timescale 1ns/1ps
// Contract
// - Answer address 010000 plus the strapped select pin as lowest bit.
// - Address byte bit 0 gives direction: one reads, zero writes.
// - First byte after a write address is stored as the pointer.
// - Pointer bit 6 clear: low bits pick the eight base registers 00h-07h.
// - Pointer bit 6 set: low bits pick extended registers 40h-4Fh.
// - Pointer is loaded only by the command byte and never read back.
// - Output and direction registers are read/write and reset to all ones.
// - Polarity inversion registers are read/write and reset to zero.
// - Four drive-strength registers 40h-43h reset to all ones.
// - Input latch enables 44h-45h are read/write and reset to zero.
// - Pull enables reset to zero, pull selects reset to ones, all read/write.
// - Interrupt masks 4Ah-4Bh are read/write and reset to all ones.
// - Interrupt status 4Ch-4Dh is read-only and resets to zero.
// - Output mode register 4Fh is read/write and resets to zero.
// - Writes aimed at the input registers are ignored.
// - Direction bit one makes the pin an input, zero an output.
// - Inversion bit one stores the inverted pin level in the input register.
// - Reading an output register returns the written value, not the pin.
module ioxp_expander #(
  parameter int PINS = 16
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic addr_sel_i,
  input wire logic [PINS-1:0] port_i,
  output logic [PINS-1:0] port_o,
  output logic [PINS-1:0] port_oe_o,
  output logic [2*PINS-1:0] drive_level_o,
  output logic [PINS-1:0] pull_enable_o,
  output logic [PINS-1:0] pull_select_o,
  output logic int_n_o
);

  // The map holds exactly two 8-bit ports
  if (PINS != 16)
  begin : g_pins_check
    $error("ioxp_expander supports PINS = 16 only");
  end

  localparam int SYNC_W = PINS + 3;

  logic rst_meta_r, rst_sync_r;
  logic [SYNC_W-1:0] sync_meta_r, sync_r;
  logic [7:0] ptr_r, ptr_nxt;
  logic [7:0] rw_r [ioxp_pkg::IOXP_NRW];
  logic [PINS-1:0] pin_prev_r, ref_r, ref_nxt, flag_r, flag_nxt, cap_r, cap_nxt;
  logic [PINS-1:0] port_oe_r, port_oe_nxt;
  logic int_n_r, int_n_nxt;
  logic slv_wr_stb, slv_wr_cmd, slv_rd_stb, slv_sda_oe;
  logic [7:0] slv_wr_data;
  logic [7:0] rd_data_w;

  // Bank slot of a pointer value, or none for read-only and unlisted ones
  function automatic logic [4:0] rw_slot(input logic [7:0] p);
    logic [4:0] s;
    s = ioxp_pkg::IOXP_SLOT_NONE;
    if (!p[ioxp_pkg::IOXP_PTR_EXT_BIT])
    begin
      if (p >= ioxp_pkg::IOXP_OFF_OUTPUT0 && p <= ioxp_pkg::IOXP_OFF_DIR1)
        s = 5'(p - ioxp_pkg::IOXP_OFF_OUTPUT0);
    end
    else if (p >= ioxp_pkg::IOXP_OFF_DRIVE0_LO && p <= ioxp_pkg::IOXP_OFF_MASK1)
      s = 5'(p - ioxp_pkg::IOXP_OFF_DRIVE0_LO) + ioxp_pkg::IOXP_SLOT_DRIVE;
    else if (p == ioxp_pkg::IOXP_OFF_MODE)
      s = ioxp_pkg::IOXP_SLOT_MODE;
    return s;
  endfunction

  // Reset is applied at once but released through two flops
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  wire rst_n = rst_sync_r;

  // Two-flop synchronisers for every pin input
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync_meta_r <= '1;
      sync_r <= '1;
    end
    else
    begin
      sync_meta_r <= {addr_sel_i, sda_i, scl_i, port_i};
      sync_r <= sync_meta_r;
    end
  end

  wire [PINS-1:0] pin_w = sync_r[PINS-1:0];
  wire scl_s = sync_r[PINS];
  wire sda_s = sync_r[PINS+1];
  wire addr_sel_s = sync_r[PINS+2];

  // Serial byte engine
  ioxp_i2c_slave u_slave (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n),
    .scl_i(scl_s),
    .sda_i(sda_s),
    .addr_sel_i(addr_sel_s),
    .rd_data_i(rd_data_w),
    .sda_oe_o(slv_sda_oe),
    .wr_stb_o(slv_wr_stb),
    .wr_cmd_o(slv_wr_cmd),
    .wr_data_o(slv_wr_data),
    .rd_stb_o(slv_rd_stb)
  );

  // Open drain: the data pin only ever pulls low
  assign sda_o = 1'b0;
  assign sda_oe_o = slv_sda_oe;

  // Decode of the current pointer
  wire [4:0] slot_w = rw_slot(ptr_r);
  wire slot_ok = (slot_w != ioxp_pkg::IOXP_SLOT_NONE);
  wire data_wr = slv_wr_stb & ~slv_wr_cmd;
  wire bank_wr = data_wr & slot_ok;
  wire hit_in0 = (ptr_r == ioxp_pkg::IOXP_OFF_INPUT0);
  wire hit_in1 = (ptr_r == ioxp_pkg::IOXP_OFF_INPUT1);
  wire hit_fl0 = (ptr_r == ioxp_pkg::IOXP_OFF_FLAGS0);
  wire hit_fl1 = (ptr_r == ioxp_pkg::IOXP_OFF_FLAGS1);
  wire hit_mode = (ptr_r == ioxp_pkg::IOXP_OFF_MODE);

  // Pointer: loaded by a command byte; moves to the pair partner after
  // each data byte except at 4Fh, so a pair streams without a new command
  always_comb
  begin
    ptr_nxt = ptr_r;
    if (slv_wr_stb && slv_wr_cmd)
      ptr_nxt = slv_wr_data;
    else if ((data_wr || slv_rd_stb) && !hit_mode)
      ptr_nxt = {ptr_r[7:1], ~ptr_r[0]};
  end

  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      ptr_r <= ioxp_pkg::IOXP_RST_PTR;
    else
      ptr_r <= ptr_nxt;
  end

  // Read/write bank, one register per slot with its own reset value
  for (genvar i = 0; i < ioxp_pkg::IOXP_NRW; i++)
  begin : g_bank
    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
      if (!rst_n)
        rw_r[i] <= ioxp_pkg::IOXP_RW_RST[i];
      else if (bank_wr && slot_w == 5'(i))
        rw_r[i] <= slv_wr_data;
    end
  end

  // Named views of the bank, port 1 in the upper byte
  wire [PINS-1:0] out_w = {rw_r[ioxp_pkg::IOXP_SLOT_OUTPUT + 5'h01],
                           rw_r[ioxp_pkg::IOXP_SLOT_OUTPUT]};
  wire [PINS-1:0] inv_w = {rw_r[ioxp_pkg::IOXP_SLOT_INVERT + 5'h01],
                           rw_r[ioxp_pkg::IOXP_SLOT_INVERT]};
  wire [PINS-1:0] dir_w = {rw_r[ioxp_pkg::IOXP_SLOT_DIR + 5'h01],
                           rw_r[ioxp_pkg::IOXP_SLOT_DIR]};
  wire [PINS-1:0] latch_w = {rw_r[ioxp_pkg::IOXP_SLOT_LATCH + 5'h01],
                             rw_r[ioxp_pkg::IOXP_SLOT_LATCH]};
  wire [PINS-1:0] mask_w = {rw_r[ioxp_pkg::IOXP_SLOT_MASK + 5'h01],
                            rw_r[ioxp_pkg::IOXP_SLOT_MASK]};
  wire [7:0] mode_w = rw_r[ioxp_pkg::IOXP_SLOT_MODE];
  wire [PINS-1:0] od_w = {{8{mode_w[ioxp_pkg::IOXP_MODE_OD1_BIT]}},
                          {8{mode_w[ioxp_pkg::IOXP_MODE_OD0_BIT]}}};

  // Configuration straight to the pad controls
  assign drive_level_o = {rw_r[ioxp_pkg::IOXP_SLOT_DRIVE + 5'h03],
                          rw_r[ioxp_pkg::IOXP_SLOT_DRIVE + 5'h02],
                          rw_r[ioxp_pkg::IOXP_SLOT_DRIVE + 5'h01],
                          rw_r[ioxp_pkg::IOXP_SLOT_DRIVE]};
  assign pull_enable_o = {rw_r[ioxp_pkg::IOXP_SLOT_PULL_EN + 5'h01],
                          rw_r[ioxp_pkg::IOXP_SLOT_PULL_EN]};
  assign pull_select_o = {rw_r[ioxp_pkg::IOXP_SLOT_PULL_SEL + 5'h01],
                          rw_r[ioxp_pkg::IOXP_SLOT_PULL_SEL]};

  // Input change tracking. A flag is raised by a real edge on an
  // unmasked input pin; reading the matching input register clears it.
  // Edges, not level differences, set flags so a read can actually clear.
  wire [PINS-1:0] rd_clr_w = {{8{slv_rd_stb & hit_in1}}, {8{slv_rd_stb & hit_in0}}};
  wire [PINS-1:0] edge_w = (pin_w ^ pin_prev_r) & dir_w & ~mask_w;
  wire [PINS-1:0] differ_w = (pin_w ^ ref_r) & dir_w;
  // Latched inputs hold the captured level while their flag stands
  wire [PINS-1:0] view_w = (latch_w & flag_r & cap_r) | (~(latch_w & flag_r) & pin_w);
  wire [PINS-1:0] in_reg_w = view_w ^ inv_w;

  always_comb
  begin
    // Set wins over the read clear; a standing flag ignores new edges, but an unlatched one drops when the pin returns
    flag_nxt = (edge_w & (~flag_r | rd_clr_w)) | (flag_r & ~rd_clr_w & (latch_w | differ_w));
    // Reference keeps the level from before the edge, frozen while flagged
    ref_nxt = ((~flag_r | rd_clr_w) & pin_prev_r) | (flag_r & ~rd_clr_w & ref_r);
    cap_nxt = ((edge_w & ~flag_r) & pin_w) | (~(edge_w & ~flag_r) & cap_r);
    int_n_nxt = ~|flag_nxt;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flag_r <= {ioxp_pkg::IOXP_RST_FLAGS, ioxp_pkg::IOXP_RST_FLAGS};
      pin_prev_r <= '1; // Matches the prefilled synchronisers, no false edge
      ref_r <= '0;
      cap_r <= '0;
      int_n_r <= 1'b1;
    end
    else
    begin
      flag_r <= flag_nxt;
      pin_prev_r <= pin_w;
      ref_r <= ref_nxt;
      cap_r <= cap_nxt;
      int_n_r <= int_n_nxt;
    end
  end

  assign int_n_o = int_n_r;

  // Read mux; output registers return the stored value, never the pin
  assign rd_data_w = hit_in0 ? in_reg_w[7:0] :
                     hit_in1 ? in_reg_w[15:8] :
                     hit_fl0 ? flag_r[7:0] :
                     hit_fl1 ? flag_r[15:8] :
                     slot_ok ? rw_r[slot_w] : 8'h00;

  // Pin drivers: inputs float; open-drain ports drive only a low
  assign port_oe_nxt = ~dir_w & ~(od_w & out_w);

  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      port_oe_r <= '0;
    else
      port_oe_r <= port_oe_nxt;
  end

  assign port_o = out_w;
  assign port_oe_o = port_oe_r;

endmodule // ioxp_expander

// file: tb/ioxp_expander_monitor.sv
// Checker bound to the expander top: reset values, SDA turn-around,
// address match and stability of the pin-side outputs.
// Assumes SCL and SDA ports carry the resolved bus levels.
`timescale 1ns/1ps
module ioxp_expander_monitor #(
  parameter int PINS = 16
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_oe_o,
  input wire logic addr_sel_i,
  input wire logic [PINS-1:0] port_o,
  input wire logic [PINS-1:0] port_oe_o,
  input wire logic [2*PINS-1:0] drive_level_o,
  input wire logic [PINS-1:0] pull_enable_o,
  input wire logic [PINS-1:0] pull_select_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  logic scl_q, sda_q, first_r;
  logic [3:0] bit_r;
  logic [7:0] shift_r;
  wire start_w = scl_i && scl_q && sda_q && !sda_i;
  wire rise_w = scl_i && !scl_q;
  wire match_w = shift_r[7:1] == {ioxp_pkg::IOXP_ADDR_HI, addr_sel_i};
  // Own bus decoder, so the address check does not trust the design
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
    if (!reset_n_i)
      {scl_q, sda_q, first_r, bit_r, shift_r} <= {2'b11, 13'h0};
    else
    begin
      {scl_q, sda_q} <= {scl_i, sda_i};
      if (start_w)
        {first_r, bit_r} <= 5'h10;
      else if (rise_w && bit_r == 4'h8)
        {first_r, bit_r} <= 5'h00;
      else if (rise_w)
        {bit_r, shift_r} <= {bit_r + 4'h1, shift_r[6:0], sda_i};
    end
  // Properties
  property p_rst_pins; $rose(reset_n_i) |-> port_o == '1 && port_oe_o == '0
    && drive_level_o == '1 && pull_enable_o == '0 && pull_select_o == '1; endproperty
  a_rst_pins: assert property (p_rst_pins)
    else $error("pin outputs not at defaults after reset");
  property p_rst_quiet; $rose(reset_n_i) |-> !sda_oe_o [*3]; endproperty
  a_rst_quiet: assert property (p_rst_quiet)
    else $error("data line pulled right after reset");
  property p_addr_ack; rise_w && bit_r == 4'h8 && first_r |-> ##2 sda_oe_o == match_w; endproperty
  a_addr_ack: assert property (p_addr_ack)
    else $error("address acknowledge does not follow address match");
  property p_sda_turn; $changed(sda_oe_o) |-> !scl_i && !$past(scl_i); endproperty
  a_sda_turn: assert property (p_sda_turn)
    else $error("data line changed while clock high");
  property p_ack_lasts; $rose(sda_oe_o) |-> sda_oe_o [*4]; endproperty
  a_ack_lasts: assert property (p_ack_lasts)
    else $error("data line low pulse too short");
  property p_port_hold; $changed(port_o) |-> !scl_i; endproperty
  a_port_hold: assert property (p_port_hold)
    else $error("output value changed outside a write acknowledge");
  property p_cfg_hold; $changed({drive_level_o, pull_enable_o, pull_select_o})
    |-> $stable(scl_i) && !scl_i; endproperty
  a_cfg_hold: assert property (p_cfg_hold)
    else $error("pin configuration changed outside a write");
  property p_oe_hold; $changed(port_oe_o) |-> !scl_i ##1 !scl_i; endproperty
  a_oe_hold: assert property (p_oe_hold)
    else $error("pin enables changed outside a write");
endmodule // ioxp_expander_monitor

bind ioxp_expander ioxp_expander_monitor #(.PINS(PINS)) u_monitor (
  .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .scl_i(scl_i), .sda_i(sda_i),
  .sda_oe_o(sda_oe_o), .addr_sel_i(addr_sel_i), .port_o(port_o), .port_oe_o(port_oe_o),
  .drive_level_o(drive_level_o), .pull_enable_o(pull_enable_o),
  .pull_select_o(pull_select_o));

// file: tb/ioxp_master_model.sv
// Bus master model for the expander's two-wire port.
// Assumes a pull-up on SDA: a released line reads high.
`timescale 1ns/1ps
module ioxp_master_model (
  input wire logic clk_i,
  input wire logic sda_oe_i,
  output logic scl_o,
  output logic sda_o
);
  logic drv_r = 1'b1;
  initial scl_o = 1'b1;
  // Wired-and of both parties
  assign sda_o = drv_r & ~sda_oe_i;
  // Slow edges: 8 cycles per half period keeps clear of the sync lag
  task automatic step(input logic c, input logic d, input int n);
    scl_o = c;
    drv_r = d;
    repeat (n) @(negedge clk_i);
  endtask
  task automatic start();
    step(scl_o, 1'b1, 8);
    step(1'b1, 1'b1, 8);
    step(1'b1, 1'b0, 8);
    step(1'b0, 1'b0, 4);
  endtask
  task automatic stop();
    step(1'b0, 1'b0, 4);
    step(1'b1, 1'b0, 8);
    step(1'b1, 1'b1, 8);
  endtask
  // One bit, line sampled mid-high
  task automatic pulse(input logic b, output logic s);
    step(1'b0, b, 4);
    step(1'b1, b, 4);
    s = sda_o;
    step(1'b1, b, 4);
    step(1'b0, b, 4);
  endtask
  task automatic put(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      pulse(d[i], s);
    pulse(1'b1, s);
    ack = ~s;
  endtask
  // Last byte of a read ends with a not-acknowledge
  task automatic get(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      pulse(1'b1, s);
      d[i] = s;
    end
    pulse(last, s);
  endtask
endmodule // ioxp_master_model

// file: tb/tb_i2c_io_expander_command_map.sv
// Bench for the I/O expander: reset values, register bank, address
// match, pointer, pin effects and a reset in mid-run.
// Assumes the master model resolves SDA and the checker is bound.
`timescale 1ns/1ps
module tb_i2c_io_expander_command_map;
  logic ref_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic addr_sel_i = 1'b1;
  logic [15:0] port_i = 16'h3C96;
  logic [6:0] dev = 7'h21;
  logic scl, sda, sda_o, sda_oe, int_n, ack;
  logic [15:0] port_o, port_oe, pull_en, pull_sel;
  logic [31:0] drive;
  logic [7:0] rd;
  logic [7:0] holes [6] = '{8'h08, 8'h3F, 8'h4C, 8'h4E, 8'h50, 8'hFF};
  int bad_count = 0;
  int compares = 0;
  initial
    forever #5 ref_clk_i = ~ref_clk_i;
  ioxp_master_model m (.clk_i(ref_clk_i), .sda_oe_i(sda_oe), .scl_o(scl), .sda_o(sda));
  ioxp_expander #(.PINS(16)) dut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe), .addr_sel_i(addr_sel_i),
    .port_i(port_i), .port_o(port_o), .port_oe_o(port_oe), .drive_level_o(drive),
    .pull_enable_o(pull_en), .pull_select_o(pull_sel), .int_n_o(int_n));
  // Pattern differs per register, so a wrong slot shows
  function automatic logic [7:0] pat(input logic [7:0] o);
    return o ^ 8'hA5;
  endfunction
  // Bank in map order: 02h-07h, 40h-4Bh, 4Fh
  function automatic logic [7:0] off(input int i);
    return (i < 6) ? 8'(i + 2) : (i < 18) ? 8'(i + 58) : 8'h4F;
  endfunction
  function automatic logic [7:0] rstv(input logic [7:0] o);
    return (o inside {8'h04, 8'h05, [8'h44:8'h47], 8'h4F}) ? 8'h00 : 8'hFF;
  endfunction
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Address, command byte, optional data byte; ok is the expected ack
  task automatic wr(input logic [7:0] o, input logic [7:0] d, input bit data, input logic ok);
    m.start();
    m.put({dev, 1'b0}, ack);
    chk(ack, ok);
    if (ok)
    begin
      m.put(o, ack);
      chk(ack, 1'b1);
      if (data)
      begin
        m.put(d, ack);
        chk(ack, 1'b1);
      end
    end
    m.stop();
  endtask
  // With cmd clear the stored pointer is used as it stands
  task automatic rdc(input bit cmd, input logic [7:0] o, input logic [7:0] exp);
    if (cmd)
      wr(o, 8'h00, 1'b0, 1'b1);
    m.start();
    m.put({dev, 1'b1}, ack);
    chk(ack, 1'b1);
    m.get(1'b1, rd);
    m.stop();
    chk(rd, exp);
  endtask
  task automatic defaults();
    chk({port_o, port_oe, pull_en, pull_sel}, 64'hFFFF_0000_0000_FFFF);
    chk({sda_o, int_n, drive}, 34'h1_FFFF_FFFF);
    for (int i = 0; i < 19; i++)
      rdc(1'b1, off(i), rstv(off(i)));
    rdc(1'b1, 8'h4C, 8'h00);
    rdc(1'b1, 8'h4D, 8'h00);
  endtask
  initial
  begin
    repeat (4) @(negedge ref_clk_i);
    reset_n_i = 1'b1;
    repeat (6) @(negedge ref_clk_i);
    defaults();
    $display("reset values test done");
    dev = 7'h20;
    wr(8'h02, 8'h00, 1'b1, 1'b0);
    dev = 7'h21;
    rdc(1'b1, 8'h02, 8'hFF);
    for (int i = 0; i < 19; i++)
    begin
      wr(off(i), pat(off(i)), 1'b1, 1'b1);
      rdc(1'b1, off(i), pat(off(i)));
    end
    chk({drive, pull_en, pull_sel}, 64'hE6E7E4E5_E2E3_ECED);
    // Mode EAh: port 1 open-drain, so its driven highs are released
    chk({port_o, port_oe}, 32'hA6A7_595C);
    $display("register bank test done");
    rdc(1'b1, 8'h00, 8'h96 ^ 8'hA1);
    rdc(1'b1, 8'h01, 8'h3C ^ 8'hA0);
    wr(8'h04, 8'h00, 1'b1, 1'b1);
    wr(8'h00, 8'h55, 1'b1, 1'b1);
    rdc(1'b1, 8'h00, 8'h96);
    for (int k = 0; k < 6; k++)
    begin
      wr(holes[k], 8'h5A, 1'b1, 1'b1);
      rdc(1'b1, holes[k], 8'h00);
    end
    rdc(1'b1, 8'h4F, 8'hEA);
    // Unmasked input pin falls: flag and interrupt until the input read
    wr(8'h4A, 8'h00, 1'b1, 1'b1);
    port_i[1] = 1'b0;
    rdc(1'b1, 8'h4C, 8'h02);
    chk(int_n, 1'b0);
    rdc(1'b1, 8'h00, 8'h94);
    chk(int_n, 1'b1);
    $display("input and hole test done");
    wr(8'h06, 8'h00, 1'b0, 1'b1);
    rdc(1'b0, 8'h00, 8'hA3);
    rdc(1'b0, 8'h00, 8'hA2);
    // Two-byte read streams the pair 06h, 07h
    m.start();
    m.put({dev, 1'b1}, ack);
    chk(ack, 1'b1);
    m.get(1'b0, rd);
    chk(rd, 8'hA3);
    m.get(1'b1, rd);
    m.stop();
    chk(rd, 8'hA2);
    addr_sel_i = 1'b0;
    dev = 7'h20;
    rdc(1'b1, 8'h02, 8'hA7);
    dev = 7'h21;
    wr(8'h02, 8'h00, 1'b1, 1'b0);
    addr_sel_i = 1'b1;
    $display("pointer and address test done");
    reset_n_i = 1'b0;
    repeat (4) @(negedge ref_clk_i);
    reset_n_i = 1'b1;
    repeat (6) @(negedge ref_clk_i);
    defaults();
    $display("mid-run reset test done");
    report_and_stop();
  end
  // Hang guard
  initial
  begin
    repeat (90000) @(posedge ref_clk_i);
    bad_count++;
    report_and_stop();
  end
endmodule // tb_i2c_io_expander_command_map
